/* hw/sysclk_pkg.sv */
package sysclk_pkg;
    // =========================================================
    // Register indices (byte address = 4 * index)
    localparam logic [11:0] idx_feedback_div     = 12'h200;
    localparam logic [11:0] idx_input_config     = 12'h201;
    localparam logic [11:0] idx_ref_freq_byte0   = 12'h202;
    localparam logic [11:0] idx_ref_freq_byte1   = 12'h203;
    localparam logic [11:0] idx_ref_freq_byte2   = 12'h204;
    localparam logic [11:0] idx_ref_freq_top     = 12'h205;
    localparam logic [11:0] idx_stab_byte0       = 12'h206;
    localparam logic [11:0] idx_stab_byte1       = 12'h207;
    localparam logic [11:0] idx_stab_top         = 12'h208;
    localparam logic [11:0] idx_transfer_strobe  = 12'h00F;
    localparam logic [11:0] idx_status           = 12'h210;
    localparam logic [11:0] idx_irq_status       = 12'h211;
    localparam logic [11:0] idx_irq_mask         = 12'h212;

    // =========================================================
    // Field positions and reset values
    localparam int          bit_crystal_amp      = 3;
    localparam int          bit_predivider_lo    = 1;
    localparam int          bit_doubler          = 0;
    localparam logic [7:0]  rst_input_config     = 8'h08;
    localparam logic [7:0]  mask_input_config    = 8'h0F;
    localparam logic [7:0]  mask_nibble          = 8'h0F;
    localparam logic [7:0]  rst_stab_byte0       = 8'h32;
    localparam logic [7:0]  rst_zero             = 8'h00;
    localparam logic [7:0]  strobe_value         = 8'h01;
    localparam logic [7:0]  min_feedback_div     = 8'h04;

    // Interrupt status bits
    localparam int          irq_stable           = 0;
    localparam int          irq_unstable         = 1;
    localparam int          irq_lock_lost        = 2;
    localparam int          irq_width            = 3;

    // =========================================================
    // Timing
    localparam int          clk_freq_hz          = 200_000_000;
    localparam int          ms_per_s             = 1000;
    localparam int          cycles_per_ms        = clk_freq_hz / ms_per_s;
    localparam int          stab_width           = 20;
endpackage

/* hw/stability_timer.sv */
module stability_timer #(
    parameter int ms_cycles = sysclk_pkg::cycles_per_ms
) (
    input  wire logic                            clk,
    input  wire logic                            rstn,
    input  wire logic                            pll_locked,
    input  wire logic                            clear,
    input  wire logic                            start,
    input  wire logic [sysclk_pkg::stab_width-1:0] period_ms,
    output logic                                 stable
);
    // =========================================================
    // Millisecond tick divider
    logic [31:0]                     tick_cnt;
    logic                            tick;
    logic [sysclk_pkg::stab_width-1:0] ms_cnt;
    logic                            armed;

    assign tick = (tick_cnt == 32'(ms_cycles - 1));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt <= 32'h0;
        end else if (clear || !pll_locked || !armed || tick) begin
            tick_cnt <= 32'h0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end

    // Held after a period write until the next transfer strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            armed <= 1'b1;
        end else if (clear) begin
            armed <= 1'b0;                       // [RULE8]
        end else if (start) begin
            armed <= 1'b1;                       // [RULE9]
        end
    end

    // =========================================================
    // Lock qualification: any loss of lock restarts the count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ms_cnt <= '0;
            stable <= 1'b0;
        end else if (clear || start || !pll_locked || !armed) begin
            ms_cnt <= '0;                        // [RULE7] [RULE8]
            stable <= 1'b0;
        end else if (ms_cnt >= period_ms) begin
            stable <= 1'b1;                      // [RULE7]
        end else if (tick) begin
            ms_cnt <= ms_cnt + 1'b1;
        end
    end
endmodule

/* hw/sysclk_config.sv */
// Notes on behaviour
// RULE1 - Bit 3, reset 1, enables the crystal amp; 0 accepts an oscillator.
// RULE2 - Bits 2:1 select input predivide by 1, 2, 4 or 8, reset 00.
// RULE3 - Bit 0 enables the input doubler, reset 0.
// RULE4 - Software enables the doubler only with near 50% input duty cycle.
// RULE5 - 28-bit reference frequency in Hz, LSB first in four bytes, reset 0.
// RULE6 - 20-bit stability period in ms over three registers, reset 50 ms.
// RULE7 - Stable only after the PLL has stayed locked for the whole period.
// RULE8 - Any write to a stability period register resets the timer.
// RULE9 - The timer restarts on the next strobe, 0x01 written to index 0x00F.
// RULE10 - Feedback divider holds eight bits, valid 4 to 255, reset zero; the code stores any written value, 0 to 3 included.
// RULE11 - Reserved bits read zero and ignore writes.
module sysclk_config (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        pll_locked,
    output logic             crystal_amp_enable,
    output logic      [1:0]  input_predivider_select,
    output logic             input_doubler_enable,
    output logic      [7:0]  feedback_divider,
    output logic      [27:0] ref_freq_hz,
    output logic             sysclk_stable,
    output logic             irq
);
    // =========================================================
    // Bus decode
    logic [11:0] idx;
    logic        req;
    logic        wr;
    logic        rd;
    logic        aligned;

    assign aligned = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i[15:14] == 2'h0);
    assign idx     = wb_adr_i[13:2];
    assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr      = req && wb_we_i && wb_sel_i[0] && aligned;
    assign rd      = req && !wb_we_i && aligned;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    // =========================================================
    // Configuration registers
    logic [7:0]  input_config;
    logic [7:0]  freq_b0;
    logic [7:0]  freq_b1;
    logic [7:0]  freq_b2;
    logic [7:0]  freq_top;
    logic [7:0]  stab_b0;
    logic [7:0]  stab_b1;
    logic [7:0]  stab_top;
    logic [7:0]  fb_div;
    logic [7:0]  wdat;

    assign wdat = wb_dat_i[7:0];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            input_config <= sysclk_pkg::rst_input_config;   // [RULE1]
            fb_div       <= sysclk_pkg::rst_zero;           // [RULE10]
        end else if (wr && idx == sysclk_pkg::idx_input_config) begin
            input_config <= wdat & sysclk_pkg::mask_input_config; // [RULE11]
        end else if (wr && idx == sysclk_pkg::idx_feedback_div) begin
            fb_div       <= wdat;                           // [RULE10]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            freq_b0  <= sysclk_pkg::rst_zero;               // [RULE5]
            freq_b1  <= sysclk_pkg::rst_zero;
            freq_b2  <= sysclk_pkg::rst_zero;
            freq_top <= sysclk_pkg::rst_zero;
        end else if (wr) begin
            if (idx == sysclk_pkg::idx_ref_freq_byte0) begin
                freq_b0 <= wdat;
            end
            if (idx == sysclk_pkg::idx_ref_freq_byte1) begin
                freq_b1 <= wdat;
            end
            if (idx == sysclk_pkg::idx_ref_freq_byte2) begin
                freq_b2 <= wdat;
            end
            if (idx == sysclk_pkg::idx_ref_freq_top) begin
                freq_top <= wdat & sysclk_pkg::mask_nibble; // [RULE11]
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stab_b0  <= sysclk_pkg::rst_stab_byte0;         // [RULE6]
            stab_b1  <= sysclk_pkg::rst_zero;
            stab_top <= sysclk_pkg::rst_zero;
        end else if (wr) begin
            if (idx == sysclk_pkg::idx_stab_byte0) begin
                stab_b0 <= wdat;
            end
            if (idx == sysclk_pkg::idx_stab_byte1) begin
                stab_b1 <= wdat;
            end
            if (idx == sysclk_pkg::idx_stab_top) begin
                stab_top <= wdat & sysclk_pkg::mask_nibble; // [RULE11]
            end
        end
    end

    // =========================================================
    // Outputs to the clock path, registered
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            crystal_amp_enable      <= 1'b1;
            input_predivider_select <= 2'h0;
            input_doubler_enable    <= 1'b0;
            feedback_divider        <= sysclk_pkg::rst_zero;
            ref_freq_hz             <= 28'h0;
        end else begin
            crystal_amp_enable      <=
                input_config[sysclk_pkg::bit_crystal_amp];        // [RULE1]
            input_predivider_select <=
                input_config[sysclk_pkg::bit_predivider_lo +: 2]; // [RULE2]
            // Duty cycle is software's concern; no check here
            input_doubler_enable    <=
                input_config[sysclk_pkg::bit_doubler];            // [RULE3]
            feedback_divider        <= fb_div;
            ref_freq_hz             <= {freq_top[3:0], freq_b2,
                                        freq_b1, freq_b0};        // [RULE5]
        end
    end

    // =========================================================
    // Stability timer
    logic                              stab_write;
    logic                              transfer_strobe;
    logic                              stable_now;
    logic [sysclk_pkg::stab_width-1:0] period_ms;

    assign stab_write = wr && (idx == sysclk_pkg::idx_stab_byte0 ||
                               idx == sysclk_pkg::idx_stab_byte1 ||
                               idx == sysclk_pkg::idx_stab_top);  // [RULE8]
    assign transfer_strobe = wr && idx == sysclk_pkg::idx_transfer_strobe &&
                             wdat == sysclk_pkg::strobe_value;    // [RULE9]
    assign period_ms  = {stab_top[3:0], stab_b1, stab_b0};        // [RULE6]

    stability_timer u_timer (
        .clk        (clk),
        .rstn       (rstn),
        .pll_locked (pll_locked),
        .clear      (stab_write),
        .start      (transfer_strobe),
        .period_ms  (period_ms),
        .stable     (stable_now)
    );

    // =========================================================
    // Interrupts: sticky, cleared by reading status; set wins
    logic                          was_stable;
    logic                          was_locked;
    logic [sysclk_pkg::irq_width-1:0] irq_status;
    logic [sysclk_pkg::irq_width-1:0] irq_mask;
    logic [sysclk_pkg::irq_width-1:0] irq_event;
    logic                          status_rd;

    assign status_rd = rd && idx == sysclk_pkg::idx_irq_status;

    always_comb begin
        irq_event = '0;
        irq_event[sysclk_pkg::irq_stable]    = stable_now && !was_stable;
        irq_event[sysclk_pkg::irq_unstable]  = !stable_now && was_stable;
        irq_event[sysclk_pkg::irq_lock_lost] = !pll_locked && was_locked;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            was_stable    <= 1'b0;
            was_locked    <= 1'b0;
            sysclk_stable <= 1'b0;
        end else begin
            was_stable    <= stable_now;
            was_locked    <= pll_locked;
            sysclk_stable <= stable_now;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_status <= '0;
        end else if (status_rd) begin
            irq_status <= irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask <= '0;
        end else if (wr && idx == sysclk_pkg::idx_irq_mask) begin
            irq_mask <= wdat[sysclk_pkg::irq_width-1:0];
        end
    end

    // Registered, so irq follows status by one cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // =========================================================
    // Read mux; unmapped indices read zero
    logic [7:0] rdata;

    always_comb begin
        rdata = 8'h00;
        unique case (idx)
            sysclk_pkg::idx_feedback_div:   rdata = fb_div;
            sysclk_pkg::idx_input_config:   rdata = input_config;
            sysclk_pkg::idx_ref_freq_byte0: rdata = freq_b0;
            sysclk_pkg::idx_ref_freq_byte1: rdata = freq_b1;
            sysclk_pkg::idx_ref_freq_byte2: rdata = freq_b2;
            sysclk_pkg::idx_ref_freq_top:   rdata = freq_top;
            sysclk_pkg::idx_stab_byte0:     rdata = stab_b0;
            sysclk_pkg::idx_stab_byte1:     rdata = stab_b1;
            sysclk_pkg::idx_stab_top:       rdata = stab_top;
            sysclk_pkg::idx_status:
                rdata = {6'h0, pll_locked, stable_now};
            sysclk_pkg::idx_irq_status:
                rdata = {5'h0, irq_status};
            sysclk_pkg::idx_irq_mask:
                rdata = {5'h0, irq_mask};
            default:                        rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_dat_o <= 32'h0;
        end else if (rd) begin
            wb_dat_o <= {24'h0, rdata};
        end else begin
            wb_dat_o <= 32'h0;
        end
    end
endmodule

/* dv/sysclk_config_sva.sv */
module sysclk_config_sva (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        pll_locked,
    input wire logic        crystal_amp_enable,
    input wire logic [1:0]  input_predivider_select,
    input wire logic        input_doubler_enable,
    input wire logic [7:0]  feedback_divider,
    input wire logic [27:0] ref_freq_hz,
    input wire logic        sysclk_stable,
    input wire logic        irq
);
    logic take;
    logic wr_cfg;
    logic wr_stab;
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_cfg = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == 16'h0804);
    assign wr_stab = take & wb_we_i & wb_sel_i[0]
        & (wb_adr_i inside {16'h0818, 16'h081C, 16'h0820});
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // =========================================================
    // Bus handshake
    a_ack_after_take: assert property (take |=> wb_ack_o)
        else $error("no ack after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_dat_top_zero: assert property (wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    // =========================================================
    // Configuration and stability
    a_config_follows: assert property (wr_cfg |-> ##3
        ({crystal_amp_enable, input_predivider_select,
          input_doubler_enable} == $past(wb_dat_i[3:0], 3)))
        else $error("config outputs differ from write");
    a_stab_write_clear: assert property (wr_stab
        |-> ##4 !sysclk_stable)
        else $error("stable kept after period write");
    a_lock_loss_drop: assert property (!pll_locked ##1 !pll_locked
        |=> !sysclk_stable)
        else $error("stable without lock");
    a_rise_needs_lock: assert property ($rose(sysclk_stable)
        |-> $past(pll_locked, 2))
        else $error("stable rose without prior lock");
    cover property (wr_stab);
    cover property ($rose(sysclk_stable));
    cover property ($rose(irq));
endmodule

bind sysclk_config sysclk_config_sva u_sysclk_config_sva (
    .clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .pll_locked, .crystal_amp_enable,
    .input_predivider_select, .input_doubler_enable, .feedback_divider,
    .ref_freq_hz, .sysclk_stable, .irq);

/* dv/sysclk_config_tb_top.sv */
module sysclk_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [15:0] wb_adr_i = 16'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic        pll_locked = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        crystal_amp_enable;
    logic [1:0]  input_predivider_select;
    logic        input_doubler_enable;
    logic [7:0]  feedback_divider;
    logic [27:0] ref_freq_hz;
    logic        sysclk_stable;
    logic        irq;
    logic [31:0] q;
    logic [7:0]  rst_tab [9] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00,
                                 8'h32, 8'h00, 8'h00};
    int          bad_count = 0;
    int          total_checks = 0;
    int          cycles = 0;

    sysclk_config u_sysclk_config (
        .clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .pll_locked, .crystal_amp_enable,
        .input_predivider_select, .input_doubler_enable, .feedback_divider,
        .ref_freq_hz, .sysclk_stable, .irq);

    always #2.5 clk = ~clk;

    // =========================================================
    // Reporting
    task print_verdict;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Generous ceiling: the whole sequence needs under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            print_verdict();
        end
    end

    // =========================================================
    // Wishbone master
    task xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
              input logic [3:0] s);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= s;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 4'h1);
    endtask

    task rd(input logic [15:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00, 4'h1);
        check(q, {24'h0, exp});
    endtask

    task lock(input logic v, input int n);
        @(posedge clk);
        pll_locked <= v;
        repeat (n) @(posedge clk);
    endtask

    // =========================================================
    // Sequence
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            rd(16'h0800 + 16'(4 * i),
               rst_tab[i]);
        end
        check(crystal_amp_enable, 1'b1);
        lock(1'b1, 300);
        check(sysclk_stable, 1'b0);
        for (int i = 0; i < 4; i++) begin
            // Doubler is set only with a clean 50% input in mind
            wr(16'h0804, 8'hF0 | 8'(2 * i + i % 2));
            rd(16'h0804, 8'(2 * i + i % 2));
            check({crystal_amp_enable, input_predivider_select,
                   input_doubler_enable},
                  4'(2 * i + i % 2));
        end
        xfer(1'b1, 16'h0804, 8'h08, 4'hE);
        rd(16'h0804, 8'h07);
        wr(16'h0804, 8'h08);
        // Outputs settle one edge after the ack is seen
        @(posedge clk);
        check(crystal_amp_enable, 1'b1);
        wr(16'h0808, 8'h78);
        wr(16'h080C, 8'h56);
        wr(16'h0810, 8'h34);
        wr(16'h0814, 8'hF2);
        rd(16'h0814, 8'h02);
        check(ref_freq_hz, 28'h2345678);
        wr(16'h0800, 8'hFF);
        rd(16'h0800, 8'hFF);
        check(feedback_divider, 8'hFF);
        wr(16'h0400, 8'hAA);
        rd(16'h0400, 8'h00);
        rd(16'h0805, 8'h00);
        wr(16'h0818, 8'h00);
        wr(16'h081C, 8'h00);
        wr(16'h0820, 8'hF0);
        rd(16'h0820, 8'h00);
        repeat (20) @(posedge clk);
        check(sysclk_stable, 1'b0);
        wr(16'h003C, 8'h01);
        repeat (10) @(posedge clk);
        check(sysclk_stable, 1'b1);
        rd(16'h0840, 8'h03);
        rd(16'h0844, 8'h01);
        lock(1'b0, 5);
        check(sysclk_stable, 1'b0);
        check(irq, 1'b0);
        rd(16'h0844, 8'h06);
        wr(16'h0848, 8'h01);
        lock(1'b1, 10);
        check(irq, 1'b1);
        rd(16'h0844, 8'h01);
        repeat (3) @(posedge clk);
        check(irq, 1'b0);
        wr(16'h081C, 8'h00);
        // Timer clear needs two edges to reach the registered output
        @(posedge clk);
        check(sysclk_stable, 1'b0);
        wr(16'h003C, 8'h01);
        repeat (10) @(posedge clk);
        check(sysclk_stable, 1'b1);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(16'h0818, 8'h32);
        check(ref_freq_hz, 28'h0);
        print_verdict();
    end
endmodule
